// file: hdl/ufsf_top.sv
`timescale 1ns/1ps
// Operation
// - divide by zero sets bit 25 when trapping
// - stacked pc points at faulting divide
// - zero divisor ignored while divide trap off
// - unaligned access sets bit 24 when trapping
// - multi/doubleword unaligned always faults
// - only unaligned enable traps ordinary accesses
// - coprocessor attempt sets bit 19
// - illegal return-code load sets bit 18
// - stacked pc points at illegal pc load
// - write one clears, zero keeps
// - bits 23:20 read zero, ignore writes
// - halfword at d2a, word at d28
// - only privileged accesses reach register
module ufsf_top (
   input  wire logic        pclk,           // processor clock
   input  wire logic        presetn,        // async reset, active low
   input  wire logic        psel,           // apb select
   input  wire logic        penable,        // apb enable
   input  wire logic        pwrite,         // apb direction
   input  wire logic [13:0] paddr,          // apb byte address
   input  wire logic [31:0] pwdata,         // apb write data
   input  wire logic [3:0]  pstrb,          // apb byte strobes
   input  wire logic [2:0]  pprot,          // apb protection, bit0 privileged
   output logic [31:0]      prdata,         // apb read data
   output logic             pready,         // apb ready
   output logic             pslverr,        // apb error
   input  wire logic        div_zero_ev,    // divide with zero divisor
   input  wire logic        misal_ev,       // ordinary unaligned access
   input  wire logic        misal_multi_ev, // unaligned multi/doubleword
   input  wire logic        cop_ev,         // coprocessor attempt
   input  wire logic        badpc_ev,       // illegal return-code load
   input  wire logic [31:0] instr_pc,       // pc of the event instruction
   output logic [31:0]      stacked_pc,     // pc saved for return
   output logic             irq             // level interrupt
);
   import ufsf_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [1:0]  trap_ctrl_r, trap_ctrl_nxt;
   logic [3:0]  mask_r, mask_nxt;
   logic [31:0] pc_r, pc_nxt;
   logic [31:0] prdata_nxt;
   logic        pready_nxt, pslverr_nxt, irq_nxt;
   logic [3:0]  set_vec, clr_vec, flags;
   logic [31:0] status_word;
   logic        acc, wr, priv, hit_word, hit_half, hit_ctrl, hit_mask, hit_pc;
   logic        mapped;

   function automatic logic [31:0] flags_to_word(input logic [3:0] f);
      logic [31:0] w;
      w             = 32'h0;
      w[DIVZ_BIT]   = f[F_DIVZ];
      w[MISAL_BIT]  = f[F_MISAL];
      w[MISSING_COPROCESSOR_FLAG_BIT]   = f[F_MISSING_COPROCESSOR_FLAG];
      w[BADPC_BIT]  = f[F_BADPC];
      return w;
   endfunction

   // inverse of flags_to_word; reserved and unused bits drop out
   function automatic logic [3:0] word_to_flags(input logic [31:0] w);
      logic [3:0] f;
      f          = 4'h0;
      f[F_DIVZ]  = w[DIVZ_BIT];
      f[F_MISAL] = w[MISAL_BIT];
      f[F_MISSING_COPROCESSOR_FLAG]  = w[MISSING_COPROCESSOR_FLAG_BIT];
      f[F_BADPC] = w[BADPC_BIT];
      return f;
   endfunction

   // byte strobes widened to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // one word per register, so the byte address is the index times four
   function automatic logic at_index(input logic [13:0] a, input logic [11:0] idx);
      return (a == {idx, 2'h0});
   endfunction

   // ---------------------------------------------------------------
   // flags
   // ---------------------------------------------------------------
   ufsf_event_decode u_dec (
      .div_zero_ev    (div_zero_ev),
      .misal_ev       (misal_ev),
      .misal_multi_ev (misal_multi_ev),
      .cop_ev         (cop_ev),
      .badpc_ev       (badpc_ev),
      .trap_ctrl      (trap_ctrl_r),
      .set_vec        (set_vec)
   );

   genvar gi;
   generate
      for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
         ufsf_sticky u_flag (
            .pclk    (pclk),
            .presetn (presetn),
            .set_in  (set_vec[gi]),
            .clr_in  (clr_vec[gi]),
            .flag_r  (flags[gi])
         );
      end
   endgenerate

   assign status_word = flags_to_word(flags);

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   // one wait-free access phase; unprivileged accesses get pslverr
   always_comb begin
      acc      = psel & penable;
      wr       = acc & pwrite;
      priv     = pprot[0];
      hit_word = at_index(paddr, FAULT_STATUS_OFFSET);
      hit_half = at_index(paddr, USAGE_HALF_OFFSET);
      hit_ctrl = at_index(paddr, TRAP_CTRL_OFFSET);
      hit_mask = at_index(paddr, INT_MASK_OFFSET);
      hit_pc   = at_index(paddr, STACKED_PC_OFFSET);
      mapped   = hit_word | hit_half | hit_ctrl | hit_mask | hit_pc;
   end

   // write-one clear, upper halfword lanes only
   always_comb begin
      logic [31:0] w1c;
      w1c = 32'h0;
      if (wr && priv && (hit_word || hit_half)) begin
         // both views carry the flags on lanes 3:2; lower lanes hold none
         w1c = pwdata & lane_mask({pstrb[3:2], 2'h0});
      end
      clr_vec = word_to_flags(w1c);
   end

   // ---------------------------------------------------------------
   // control, mask, stacked pc
   // ---------------------------------------------------------------
   always_comb begin
      trap_ctrl_nxt = trap_ctrl_r;
      mask_nxt      = mask_r;
      pc_nxt        = pc_r;
      if (wr && priv && hit_ctrl && pstrb[0]) begin
         trap_ctrl_nxt = pwdata[1:0];
      end
      // mask bits sit at the same positions as the flags they gate
      if (wr && priv && hit_mask) begin
         mask_nxt = word_to_flags(pwdata & lane_mask(pstrb));
      end
      // pc of a faulting divide or illegal pc load is what the return stack holds
      if (set_vec[F_DIVZ] || set_vec[F_BADPC]) begin
         pc_nxt = instr_pc;
      end
   end

   // ---------------------------------------------------------------
   // bus answer and interrupt
   // ---------------------------------------------------------------
   always_comb begin
      pready_nxt  = psel & ~penable;
      pslverr_nxt = 1'b0;
      prdata_nxt  = 32'h0;
      if (psel && !penable) begin
         pslverr_nxt = ~priv | ~mapped;
         if (!pwrite && priv) begin
            if (hit_word || hit_half) begin
               prdata_nxt = status_word;
            end else if (hit_ctrl) begin
               prdata_nxt = {30'h0, trap_ctrl_r};
            end else if (hit_mask) begin
               prdata_nxt = flags_to_word(mask_r);
            end else if (hit_pc) begin
               prdata_nxt = pc_r;
            end
         end
      end
      irq_nxt = |(flags & mask_r);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_ctrl_r <= CTRL_RESET;
         mask_r      <= MASK_RESET;
         pc_r        <= PC_RESET;
         prdata      <= 32'h0;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         irq         <= 1'b0;
      end else begin
         trap_ctrl_r <= trap_ctrl_nxt;
         mask_r      <= mask_nxt;
         pc_r        <= pc_nxt;
         prdata      <= prdata_nxt;
         pready      <= pready_nxt;
         pslverr     <= pslverr_nxt;
         irq         <= irq_nxt;
      end
   end

   assign stacked_pc = pc_r;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_divz_set;
      @(posedge pclk) disable iff (!presetn)
      (div_zero_ev && trap_ctrl_r[CTRL_DIVZ]) |=> flags[F_DIVZ];
   endproperty
   a_divz_set: assert property (p_divz_set) else $error("divide flag not set");

   property p_divz_off;
      @(posedge pclk) disable iff (!presetn)
      (!flags[F_DIVZ] && !trap_ctrl_r[CTRL_DIVZ]) |=> !flags[F_DIVZ];
   endproperty
   a_divz_off: assert property (p_divz_off) else $error("divide flag set while off");

   property p_pc_div;
      @(posedge pclk) disable iff (!presetn)
      (div_zero_ev && trap_ctrl_r[CTRL_DIVZ]) |=> (pc_r == $past(instr_pc));
   endproperty
   a_pc_div: assert property (p_pc_div) else $error("stacked pc wrong for divide");

   property p_misal_multi;
      @(posedge pclk) disable iff (!presetn)
      misal_multi_ev |=> flags[F_MISAL];
   endproperty
   a_misal_multi: assert property (p_misal_multi) else $error("multi unaligned missed");

   property p_misal_off;
      @(posedge pclk) disable iff (!presetn)
      (!flags[F_MISAL] && !misal_multi_ev && !trap_ctrl_r[CTRL_MISAL]) |=> !flags[F_MISAL];
   endproperty
   a_misal_off: assert property (p_misal_off) else $error("unaligned flag while off");

   property p_missing_coprocessor_flag;
      @(posedge pclk) disable iff (!presetn)
      cop_ev |=> flags[F_MISSING_COPROCESSOR_FLAG];
   endproperty
   a_missing_coprocessor_flag: assert property (p_missing_coprocessor_flag) else $error("coprocessor flag not set");

   property p_badpc;
      @(posedge pclk) disable iff (!presetn)
      badpc_ev |=> (flags[F_BADPC] && pc_r == $past(instr_pc));
   endproperty
   a_badpc: assert property (p_badpc) else $error("bad pc flag or pc wrong");

   property p_clear;
      @(posedge pclk) disable iff (!presetn)
      (clr_vec[F_MISSING_COPROCESSOR_FLAG] && !set_vec[F_MISSING_COPROCESSOR_FLAG]) |=> !flags[F_MISSING_COPROCESSOR_FLAG];
   endproperty
   a_clear: assert property (p_clear) else $error("write one did not clear");

   property p_rsv;
      @(posedge pclk) disable iff (!presetn)
      (pready && (hit_word || hit_half)) |-> (prdata[RSV_HI:RSV_LO] == 4'h0);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");

   property p_unpriv;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pprot[0]) |=> (pslverr && pready);
   endproperty
   a_unpriv: assert property (p_unpriv) else $error("unprivileged access not refused");

   property p_misal_set;
      @(posedge pclk) disable iff (!presetn)
      (misal_ev && trap_ctrl_r[CTRL_MISAL]) |=> flags[F_MISAL];
   endproperty
   a_misal_set: assert property (p_misal_set) else $error("unaligned flag not set");

   property p_missing_coprocessor_flag_quiet;
      @(posedge pclk) disable iff (!presetn)
      (!flags[F_MISSING_COPROCESSOR_FLAG] && !cop_ev) |=> !flags[F_MISSING_COPROCESSOR_FLAG];
   endproperty
   a_missing_coprocessor_flag_quiet: assert property (p_missing_coprocessor_flag_quiet) else $error("coprocessor flag rose alone");

   property p_badpc_quiet;
      @(posedge pclk) disable iff (!presetn)
      (!flags[F_BADPC] && !badpc_ev) |=> !flags[F_BADPC];
   endproperty
   a_badpc_quiet: assert property (p_badpc_quiet) else $error("bad pc flag rose alone");

   property p_divz_quiet;
      @(posedge pclk) disable iff (!presetn)
      (!flags[F_DIVZ] && !div_zero_ev) |=> !flags[F_DIVZ];
   endproperty
   a_divz_quiet: assert property (p_divz_quiet) else $error("divide flag rose alone");

   property p_sticky;
      @(posedge pclk) disable iff (!presetn)
      (flags[F_MISAL] && !clr_vec[F_MISAL]) |=> flags[F_MISAL];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
      (set_vec[F_DIVZ] && clr_vec[F_DIVZ]) |=> flags[F_DIVZ];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle set");

   property p_zero_keeps;
      @(posedge pclk) disable iff (!presetn)
      (wr && priv && hit_word && !pwdata[BADPC_BIT] && flags[F_BADPC]) |=> flags[F_BADPC];
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("writing zero cleared a flag");

   property p_clear_divz;
      @(posedge pclk) disable iff (!presetn)
      (clr_vec[F_DIVZ] && !set_vec[F_DIVZ]) |=> !flags[F_DIVZ];
   endproperty
   a_clear_divz: assert property (p_clear_divz) else $error("divide flag not cleared");

   property p_unpriv_keep;
      @(posedge pclk) disable iff (!presetn)
      (wr && !priv && flags[F_DIVZ]) |=> flags[F_DIVZ];
   endproperty
   a_unpriv_keep: assert property (p_unpriv_keep) else $error("unprivileged write cleared");

   property p_err_data;
      @(posedge pclk) disable iff (!presetn)
      (pready && pslverr) |-> (prdata == 32'h0);
   endproperty
   a_err_data: assert property (p_err_data) else $error("refused access returned data");

   property p_pc_hold;
      @(posedge pclk) disable iff (!presetn)
      !(set_vec[F_DIVZ] || set_vec[F_BADPC]) |=> (pc_r == $past(pc_r));
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("stacked pc moved without fault");

   property p_irq_on;
      @(posedge pclk) disable iff (!presetn)
      (|(flags & mask_r)) |=> irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

   property p_irq_off;
      @(posedge pclk) disable iff (!presetn)
      !(|(flags & mask_r)) |=> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");

   property p_ready_pulse;
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past access");
endmodule

// file: shared/ufsf_pkg.sv
package ufsf_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   // word indices; each register owns one word at four times its index
   localparam logic [11:0] FAULT_STATUS_OFFSET = 12'hd28;
   localparam logic [11:0] USAGE_HALF_OFFSET   = 12'hd2a;
   localparam logic [11:0] TRAP_CTRL_OFFSET    = 12'h000;
   localparam logic [11:0] INT_MASK_OFFSET     = 12'h001;
   localparam logic [11:0] STACKED_PC_OFFSET   = 12'h002;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int DIVZ_BIT   = 25;
   localparam int MISAL_BIT  = 24;
   localparam int MISSING_COPROCESSOR_FLAG_BIT   = 19;
   localparam int BADPC_BIT  = 18;
   localparam int RSV_LO     = 20;
   localparam int RSV_HI     = 23;
   localparam int CTRL_DIVZ  = 0;
   localparam int CTRL_MISAL = 1;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [1:0]  CTRL_RESET   = 2'h0;
   localparam logic [3:0]  MASK_RESET   = 4'h0;
   localparam logic [31:0] PC_RESET     = 32'h0000_0000;
   localparam int          NUM_FLAGS    = 4;
   // flag index order inside the flag vector
   localparam int F_DIVZ  = 0;
   localparam int F_MISAL = 1;
   localparam int F_MISSING_COPROCESSOR_FLAG  = 2;
   localparam int F_BADPC = 3;
endpackage

// file: hdl/ufsf_sticky.sv
`timescale 1ns/1ps
// one sticky cause flag; a set wins over a write-one clear
module ufsf_sticky (
   input  wire logic pclk,    // processor clock
   input  wire logic presetn, // async reset, active low
   input  wire logic set_in,  // fault event
   input  wire logic clr_in,  // write-one clear
   output logic      flag_r   // sticky flag
);
   logic flag_nxt;

   always_comb begin
      flag_nxt = flag_r;
      if (clr_in) begin
         flag_nxt = 1'b0;
      end
      if (set_in) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end
endmodule

// file: hdl/ufsf_event_decode.sv
`timescale 1ns/1ps
// turns raw execution events into flag set pulses
module ufsf_event_decode (
   input  wire logic       div_zero_ev,   // divide with zero divisor
   input  wire logic       misal_ev,      // ordinary unaligned access
   input  wire logic       misal_multi_ev,// unaligned multi/doubleword access
   input  wire logic       cop_ev,        // coprocessor access attempt
   input  wire logic       badpc_ev,      // illegal return-code load
   input  wire logic [1:0] trap_ctrl,     // trap enables
   output logic [3:0]      set_vec        // per-flag set
);
   import ufsf_pkg::*;

   always_comb begin
      set_vec          = 4'h0;
      set_vec[F_DIVZ]  = div_zero_ev & trap_ctrl[CTRL_DIVZ];
      // multi and doubleword forms fault regardless of the enable
      set_vec[F_MISAL] = (misal_ev & trap_ctrl[CTRL_MISAL]) | misal_multi_ev;
      set_vec[F_MISSING_COPROCESSOR_FLAG]  = cop_ev;
      set_vec[F_BADPC] = badpc_ev;
   end
endmodule

// file: tb/ufsf_tb.sv
`timescale 1ns/1ps
module testbench;
   import ufsf_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [13:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [2:0]  pprot;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [4:0]  ev;
   logic [31:0] instr_pc;
   logic [31:0] stacked_pc;
   logic        irq;
   logic [31:0] rd;
   logic        er;
   int          failures;
   int          tests_run;
   int          cycles = 0;

   ufsf_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .div_zero_ev(ev[0]), .misal_ev(ev[1]),
      .misal_multi_ev(ev[2]), .cop_ev(ev[3]), .badpc_ev(ev[4]), .instr_pc(instr_pc),
      .stacked_pc(stacked_pc), .irq(irq)
   );

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // ---------------------------------------------------------------
   // reporting
   // ---------------------------------------------------------------
   task automatic final_report;
      if (failures == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // hang guard, well above the hundred or so cycles the sequence needs
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         final_report;
      end
   end

   // ---------------------------------------------------------------
   // bus tasks: entered just after a rising edge
   // ---------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [2:0] pr);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {a, 2'h0}; // a is the word index
      pwdata  <= d;
      pstrb   <= s;
      pprot   <= pr;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // pready ends this wait; the hang guard ends it if pready never comes
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle cycle keeps psel from being driven twice in one step
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf, 3'h1);
   endtask

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000, 4'hf, 3'h1);
      check(what, rd, exp);
      check("pslverr", {31'h0, er}, 32'h0000_0000);
   endtask

   task automatic pulse(input int idx, input logic [31:0] pc);
      ev[idx]  <= 1'b1;
      instr_pc <= pc;
      @(posedge pclk);
      ev[idx]  <= 1'b0;
      @(posedge pclk);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      failures = 0;
      tests_run = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 14'h0000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      pprot = 3'h0;
      ev = 5'h00;
      instr_pc = 32'h0000_0000;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk("status", FAULT_STATUS_OFFSET, STATUS_RESET);
      rdchk("trap_ctrl", TRAP_CTRL_OFFSET, {30'h0, CTRL_RESET});
      rdchk("mask", INT_MASK_OFFSET, {28'h0, MASK_RESET});
      check("stacked_pc", stacked_pc, PC_RESET);
      // traps off: ordinary divide and unaligned events are ignored
      pulse(0, 32'h0000_0040);
      pulse(1, 32'h0000_0044);
      rdchk("status", FAULT_STATUS_OFFSET, 32'h0000_0000);
      check("stacked_pc", stacked_pc, PC_RESET);
      pulse(2, 32'h0000_0048);
      rdchk("status", FAULT_STATUS_OFFSET, 32'h0100_0000);
      pulse(3, 32'h0000_004c);
      pulse(4, 32'h0000_0100);
      rdchk("status", FAULT_STATUS_OFFSET, 32'h010c_0000);
      check("stacked_pc", stacked_pc, 32'h0000_0100);
      wr(FAULT_STATUS_OFFSET, 32'h0000_0000);
      rdchk("status", FAULT_STATUS_OFFSET, 32'h010c_0000);
      wr(FAULT_STATUS_OFFSET, 32'h00f8_0000);
      rdchk("status", FAULT_STATUS_OFFSET, 32'h0104_0000);
      rdchk("half", USAGE_HALF_OFFSET, 32'h0104_0000);
      apb(1'b1, USAGE_HALF_OFFSET, 32'hffff_0000, 4'hc, 3'h1);
      rdchk("status", FAULT_STATUS_OFFSET, 32'h0000_0000);
      // divide trap alone must not catch an ordinary unaligned access
      wr(TRAP_CTRL_OFFSET, 32'h0000_0001);
      pulse(1, 32'h0000_0180);
      rdchk("status", FAULT_STATUS_OFFSET, 32'h0000_0000);
      // traps on
      wr(TRAP_CTRL_OFFSET, 32'h0000_0003);
      rdchk("trap_ctrl", TRAP_CTRL_OFFSET, 32'h0000_0003);
      pulse(0, 32'h0000_0200);
      pulse(1, 32'h0000_0300);
      rdchk("status", FAULT_STATUS_OFFSET, 32'h0300_0000);
      check("stacked_pc", stacked_pc, 32'h0000_0200);
      check("irq", {31'h0, irq}, 32'h0000_0000);
      wr(INT_MASK_OFFSET, 32'h0200_0000);
      rdchk("mask", INT_MASK_OFFSET, 32'h0200_0000);
      check("irq", {31'h0, irq}, 32'h0000_0001);
      // unprivileged clear is refused and leaves flags alone
      apb(1'b1, FAULT_STATUS_OFFSET, 32'hffff_ffff, 4'hf, 3'h0);
      check("pslverr", {31'h0, er}, 32'h0000_0001);
      rdchk("status", FAULT_STATUS_OFFSET, 32'h0300_0000);
      apb(1'b0, 12'h010, 32'h0000_0000, 4'hf, 3'h1);
      check("unmapped err", {31'h0, er}, 32'h0000_0001);
      check("unmapped data", rd, 32'h0000_0000);
      // divide event lands on the same edge as its clear
      fork
         wr(FAULT_STATUS_OFFSET, 32'h0200_0000);
         begin
            @(posedge pclk);
            ev[0]    <= 1'b1;
            instr_pc <= 32'h0000_0400;
            @(posedge pclk);
            ev[0]    <= 1'b0;
         end
      join
      rdchk("status", FAULT_STATUS_OFFSET, 32'h0300_0000);
      check("stacked_pc", stacked_pc, 32'h0000_0400);
      wr(FAULT_STATUS_OFFSET, 32'h0300_0000);
      @(posedge pclk);
      check("irq", {31'h0, irq}, 32'h0000_0000);
      rdchk("status", FAULT_STATUS_OFFSET, 32'h0000_0000);
      final_report;
   end
endmodule
